// >>> design/psc_pkg.sv
// package for the parameter store control block
package psc_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_STORE_BASE   = 8'h00;
	localparam logic [7:0] ADDR_DISCARD_BASE = 8'h40;
	localparam logic [7:0] ADDR_REBOOT       = 8'h80;
	localparam logic [7:0] ADDR_MARK_DATE    = 8'h84;
	localparam logic [7:0] ADDR_MARK_TIME    = 8'h88;
	localparam logic [7:0] ADDR_INT_STATUS   = 8'h8C;
	localparam logic [7:0] ADDR_INT_MASK     = 8'h90;
	localparam logic [7:0] ADDR_STATUS       = 8'h94;
	localparam logic [1:0] REGION_STORE      = 2'h0;
	localparam logic [1:0] REGION_DISCARD    = 2'h1;

	// command words
	localparam logic [31:0] CMD_SAVE    = 32'h65766173;
	localparam logic [31:0] CMD_DISCARD = 32'h64616F6C;
	localparam logic [31:0] CMD_REBOOT  = 32'h746F6F62;
	localparam logic [31:0] WORD_DONE   = 32'h00000001;
	localparam logic [31:0] WORD_RESET  = 32'h00000000;

	// subindices
	localparam int          NUM_SUB     = 12;
	localparam logic [3:0]  SUB_ALL     = 4'h1;
	localparam logic [3:0]  SUB_COMM    = 4'h2;
	localparam logic [3:0]  SUB_APPL    = 4'h3;
	localparam logic [3:0]  SUB_CUST    = 4'h4;
	localparam logic [3:0]  SUB_DRIVE   = 4'h5;
	localparam logic [3:0]  SUB_TUNE    = 4'h6;
	localparam logic [3:0]  SUB_MODBUS  = 4'hB;

	// category mask bits
	localparam int CAT_COMM   = 0;
	localparam int CAT_APPL   = 1;
	localparam int CAT_CUST   = 2;
	localparam int CAT_DRIVE  = 3;
	localparam int CAT_TUNE   = 4;
	localparam int CAT_MODBUS = 5;
	localparam int CAT_MARKER = 6;
	localparam int CAT_W      = 7;
	localparam logic [6:0] CATS_SAVE_ALL    = 7'h5F;
	localparam logic [6:0] CATS_DISCARD_ALL = 7'h0F;
	localparam logic [6:0] CATS_EVERY       = 7'h7F;
	localparam logic [6:0] CATS_NONE        = 7'h00;

	// interrupt status bits
	localparam int IRQ_SAVE_DONE    = 0;
	localparam int IRQ_DISCARD_DONE = 1;
	localparam int IRQ_LOAD_DONE    = 2;
	localparam int IRQ_BAD_CMD      = 3;
	localparam int IRQ_W            = 4;
	localparam logic [3:0] IRQ_RESET = 4'h0;

	typedef enum logic [1:0] {
		PSC_OP_LOAD,
		PSC_OP_SAVE,
		PSC_OP_DISCARD
	} psc_op_t;

	typedef enum logic [1:0] {
		PSC_ST_LOAD,
		PSC_ST_IDLE,
		PSC_ST_BUSY
	} psc_state_t;

	// request to the persistent storage engine
	typedef struct packed {
		logic       valid;
		psc_op_t    op;
		logic [6:0] cats;
	} psc_nv_req_t;

	// modification marker entries
	typedef struct packed {
		logic [31:0] date;
		logic [31:0] time_of_day;
	} psc_marker_t;
endpackage

// >>> design/psc_parameter_store_control.sv
// parameter store control: save, discard, reboot and modification marker
// Summary of operation
// RULE1: save word into store subindex saves category
// RULE2: finished save overwrites subindex with one
// RULE3: store subindex selects category, 01 all but fieldbus
// RULE4: master polls subindex until it reads one
// RULE5: master keeps motor still during save
// RULE6: discard word drops stored categories
// RULE7: discard subindex selects category, as the store subindex does
// RULE8: discard 01 spares tuning and fieldbus categories
// RULE9: discard affects active values only after restart
// RULE10: reboot word restarts the device
// RULE11: savable object write clears marker entries
// RULE12: marker writable, saved with save-all
// RULE13: master verifies via marker after restart; reset clears marker_out to zero here and the load does not restore it
// RULE14: stored values reload after power-up or reset
// RULE15: only whole categories are ever stored
// RULE16: wrong word starts no storage operation
// RULE17: running save subindex keeps returning command
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module psc_parameter_store_control
(
	// clock and reset
	input  wire logic                  clock_in,
	input  wire logic                  rst_n_in,
	// register port
	input  wire logic [7:0]            addr_in,
	input  wire logic [31:0]           wr_data_in,
	input  wire logic                  wr_in,
	input  wire logic                  rd_in,
	output logic [31:0]                rd_data_out,
	// savable object written elsewhere in the dictionary
	input  wire logic                  obj_write_in,
	// persistent storage engine
	output psc_pkg::psc_nv_req_t       nv_req_out,
	output psc_pkg::psc_marker_t       marker_out,
	input  wire logic                  nv_done_in,
	// system
	output logic                       reboot_out,
	output logic                       motion_lock_out,
	output logic                       irq_out
);

	psc_pkg::psc_state_t   state_reg;
	psc_pkg::psc_state_t   state_next;
	psc_pkg::psc_nv_req_t  nv_req_next;
	logic [3:0]            op_sub_reg;
	logic                  op_discard_reg;
	logic [31:0]           store_word_reg [psc_pkg::NUM_SUB];
	logic [31:0]           discard_word_reg [psc_pkg::NUM_SUB];
	psc_pkg::psc_marker_t  marker_next;
	logic [3:0]            int_status_reg;
	logic [3:0]            int_status_next;
	logic [3:0]            int_mask_reg;
	logic [31:0]           rd_data_next;

	// address decode
	wire logic [1:0] region     = addr_in[7:6];
	wire logic [3:0] sub        = addr_in[5:2];
	wire logic       sub_ok     = (sub >= psc_pkg::SUB_ALL && sub <= psc_pkg::SUB_TUNE)
	                              || sub == psc_pkg::SUB_MODBUS;
	wire logic       dis_sub_ok = sub_ok;
	wire logic       idle       = state_reg == psc_pkg::PSC_ST_IDLE;
	wire logic       wr_store   = wr_in && region == psc_pkg::REGION_STORE && sub_ok;
	wire logic       wr_discard = wr_in && region == psc_pkg::REGION_DISCARD && dis_sub_ok;
	wire logic       wr_reboot  = wr_in && addr_in == psc_pkg::ADDR_REBOOT;
	wire logic       wr_date    = wr_in && addr_in == psc_pkg::ADDR_MARK_DATE;
	wire logic       wr_time    = wr_in && addr_in == psc_pkg::ADDR_MARK_TIME;
	wire logic       wr_istat   = wr_in && addr_in == psc_pkg::ADDR_INT_STATUS;
	wire logic       wr_imask   = wr_in && addr_in == psc_pkg::ADDR_INT_MASK;

	// store and discard writes while an operation runs are refused, keeping the command word
	wire logic       take_store   = wr_store && idle;   // [RULE17]
	wire logic       take_discard = wr_discard && idle;
	wire logic       is_save      = wr_data_in == psc_pkg::CMD_SAVE;
	wire logic       is_discard   = wr_data_in == psc_pkg::CMD_DISCARD;
	wire logic       start_save   = take_store && is_save;       // [RULE1] [RULE16]
	wire logic       start_disc   = take_discard && is_discard;  // [RULE6] [RULE16]
	wire logic       bad_cmd      = (take_store && !is_save) || (take_discard && !is_discard);
	wire logic       op_done      = state_reg == psc_pkg::PSC_ST_BUSY && nv_done_in;
	wire logic       load_done    = state_reg == psc_pkg::PSC_ST_LOAD && nv_done_in;

	// store subindex to category set
	function automatic logic [6:0] save_cats(input logic [3:0] s);
		logic [6:0] c;
		c = psc_pkg::CATS_NONE;
		unique case (s)
			psc_pkg::SUB_ALL:    c = psc_pkg::CATS_SAVE_ALL;  // [RULE3] [RULE12]
			psc_pkg::SUB_COMM:   c[psc_pkg::CAT_COMM] = 1'b1;
			psc_pkg::SUB_APPL:   c[psc_pkg::CAT_APPL] = 1'b1;
			psc_pkg::SUB_CUST:   c[psc_pkg::CAT_CUST] = 1'b1;
			psc_pkg::SUB_DRIVE:  c[psc_pkg::CAT_DRIVE] = 1'b1;
			psc_pkg::SUB_TUNE:   c[psc_pkg::CAT_TUNE] = 1'b1;
			psc_pkg::SUB_MODBUS: c[psc_pkg::CAT_MODBUS] = 1'b1;
			default:             c = psc_pkg::CATS_NONE;
		endcase
		return c;
	endfunction

	// discard subindex to category set
	function automatic logic [6:0] discard_cats(input logic [3:0] s);
		logic [6:0] c;
		c = save_cats(s);  // [RULE7]
		if (s == psc_pkg::SUB_ALL)
		begin
			c = psc_pkg::CATS_DISCARD_ALL;  // [RULE8]
		end
		return c;
	endfunction

	// operation sequencing
	always_comb
	begin
		state_next  = state_reg;
		nv_req_next = nv_req_out;
		unique case (state_reg)
			psc_pkg::PSC_ST_LOAD:
			begin
				if (nv_done_in)
				begin
					state_next        = psc_pkg::PSC_ST_IDLE;
					nv_req_next.valid = 1'b0;
				end
			end
			psc_pkg::PSC_ST_IDLE:
			begin
				if (start_save)
				begin
					state_next  = psc_pkg::PSC_ST_BUSY;
					nv_req_next = '{1'b1, psc_pkg::PSC_OP_SAVE, save_cats(sub)};  // [RULE15]
				end
				else if (start_disc)
				begin
					state_next  = psc_pkg::PSC_ST_BUSY;
					nv_req_next = '{1'b1, psc_pkg::PSC_OP_DISCARD, discard_cats(sub)};  // [RULE9]
				end
			end
			psc_pkg::PSC_ST_BUSY:
			begin
				if (nv_done_in)
				begin
					state_next        = psc_pkg::PSC_ST_IDLE;
					nv_req_next.valid = 1'b0;
				end
			end
		endcase
	end

	// marker entries: written by software, cleared by any other savable write
	wire logic mark_clear = obj_write_in || (wr_store && sub != psc_pkg::SUB_ALL);  // [RULE11]
	always_comb
	begin
		marker_next = marker_out;
		if (mark_clear)
		begin
			marker_next = '0;  // [RULE11]
		end
		if (wr_date)
		begin
			marker_next.date = wr_data_in;  // [RULE12]
		end
		if (wr_time)
		begin
			marker_next.time_of_day = wr_data_in;  // [RULE12]
		end
	end

	// sticky interrupt status, a new event wins over a clear
	wire logic [3:0] irq_set = {bad_cmd, load_done,
	                            op_done && op_discard_reg, op_done && !op_discard_reg};
	wire logic [3:0] irq_clr = wr_istat ? wr_data_in[3:0] : 4'h0;
	assign int_status_next = (int_status_reg & ~irq_clr) | irq_set;

	// read mux
	always_comb
	begin
		rd_data_next = '0;
		if (rd_in)
		begin
			if (region == psc_pkg::REGION_STORE && sub_ok)
			begin
				rd_data_next = store_word_reg[sub];  // [RULE4]
			end
			else if (region == psc_pkg::REGION_DISCARD && dis_sub_ok)
			begin
				rd_data_next = discard_word_reg[sub];
			end
			else
			begin
				unique case (addr_in)
					psc_pkg::ADDR_MARK_DATE:  rd_data_next = marker_out.date;
					psc_pkg::ADDR_MARK_TIME:  rd_data_next = marker_out.time_of_day;
					psc_pkg::ADDR_INT_STATUS: rd_data_next = {28'h0, int_status_reg};
					psc_pkg::ADDR_INT_MASK:   rd_data_next = {28'h0, int_mask_reg};
					psc_pkg::ADDR_STATUS:     rd_data_next = {30'h0, state_reg};
					default:                  rd_data_next = '0;
				endcase
			end
		end
	end

	// control and bus registers
	always_ff @(posedge clock_in)
	begin
		if (!rst_n_in)
		begin
			state_reg       <= psc_pkg::PSC_ST_LOAD;
			nv_req_out      <= '{1'b1, psc_pkg::PSC_OP_LOAD, psc_pkg::CATS_EVERY};  // [RULE14]
			marker_out      <= '0;
			int_status_reg  <= psc_pkg::IRQ_RESET;
			int_mask_reg    <= psc_pkg::IRQ_RESET;
			rd_data_out     <= '0;
			reboot_out      <= 1'b0;
			irq_out         <= 1'b0;
			motion_lock_out <= 1'b1;
			op_sub_reg      <= 4'h0;
			op_discard_reg  <= 1'b0;
		end
		else
		begin
			state_reg       <= state_next;
			nv_req_out      <= nv_req_next;
			marker_out      <= marker_next;
			int_status_reg  <= int_status_next;
			rd_data_out     <= rd_data_next;
			reboot_out      <= wr_reboot && wr_data_in == psc_pkg::CMD_REBOOT;  // [RULE10]
			irq_out         <= |(int_status_next & int_mask_reg);
			motion_lock_out <= state_next != psc_pkg::PSC_ST_IDLE;  // [RULE5]
			if (wr_imask)
			begin
				int_mask_reg <= wr_data_in[3:0];
			end
			if (start_save || start_disc)
			begin
				op_sub_reg     <= sub;
				op_discard_reg <= start_disc;
			end
		end
	end

	// subindex words
	always_ff @(posedge clock_in)
	begin
		if (!rst_n_in)
		begin
			for (int i = 0; i < psc_pkg::NUM_SUB; i++)
			begin
				store_word_reg[i]   <= psc_pkg::WORD_RESET;
				discard_word_reg[i] <= psc_pkg::WORD_RESET;
			end
		end
		else
		begin
			if (take_store)
			begin
				store_word_reg[sub] <= wr_data_in;
			end
			if (take_discard)
			begin
				discard_word_reg[sub] <= wr_data_in;
			end
			if (op_done && !op_discard_reg)
			begin
				store_word_reg[op_sub_reg] <= psc_pkg::WORD_DONE;  // [RULE2]
			end
			if (op_done && op_discard_reg)
			begin
				discard_word_reg[op_sub_reg] <= psc_pkg::WORD_DONE;
			end
		end
	end

endmodule

`default_nettype wire

// >>> sim/psc_nv_model.sv
// storage engine model answering the store control's requests
`timescale 1ns/10ps
`default_nettype none
module psc_nv_model
(
	// clock and reset
	input  wire logic                 clock_in,
	input  wire logic                 rst_n_in,
	// request link
	input  wire psc_pkg::psc_nv_req_t nv_req_in,
	input  wire logic                 slow_in,
	output logic                      nv_done_out
);
	logic [4:0] wait_reg;
	always_ff @(posedge clock_in)
	begin
		if (!rst_n_in || !nv_req_in.valid || nv_done_out)
			wait_reg <= 5'h00;
		else
			wait_reg <= wait_reg + 5'h01;
	end
	// one-cycle done after a short or a long wait
	assign nv_done_out = nv_req_in.valid && (wait_reg == (slow_in ? 5'h14 : 5'h02));
endmodule
`default_nettype wire

// >>> sim/psc_parameter_store_control_assertions.sv
// assertions for the parameter store control block
`timescale 1ns/10ps
`default_nettype none
module psc_parameter_store_control_assertions
(
	// block inputs
	input wire logic                 clock_in,
	input wire logic                 rst_n_in,
	input wire logic [7:0]           addr_in,
	input wire logic [31:0]          wr_data_in,
	input wire logic                 wr_in,
	input wire logic                 rd_in,
	input wire logic                 obj_write_in,
	input wire logic                 nv_done_in,
	// block outputs
	input wire logic [31:0]          rd_data_out,
	input wire psc_pkg::psc_nv_req_t nv_req_out,
	input wire psc_pkg::psc_marker_t marker_out,
	input wire logic                 reboot_out,
	input wire logic                 motion_lock_out,
	input wire logic                 irq_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	wire logic idle = !motion_lock_out && !nv_req_out.valid;
	wire logic boot = wr_in && addr_in == 8'h80 && wr_data_in == 32'h746F6F62;
	a_save_all: assert property (
		wr_in && addr_in == 8'h04 && wr_data_in == 32'h65766173 && idle
		|=> nv_req_out == {3'h5, 7'h5F}) else $error("save-all request wrong");
	a_discard_all: assert property (
		wr_in && addr_in == 8'h44 && wr_data_in == 32'h64616F6C && idle
		|=> nv_req_out == {3'h6, 7'h0F}) else $error("discard-all request wrong");
	a_bad_word: assert property (
		wr_in && addr_in[7:6] == 2'h0 && wr_data_in != 32'h65766173 && idle
		|=> !nv_req_out.valid) else $error("wrong word started storage");
	a_done_release: assert property (nv_req_out.valid && nv_done_in
		|=> !nv_req_out.valid && !motion_lock_out) else $error("request not released");
	a_req_steady: assert property (nv_req_out.valid && !nv_done_in
		|=> $stable(nv_req_out)) else $error("request changed while busy");
	a_lock_busy: assert property (nv_req_out.valid |-> motion_lock_out)
		else $error("motion not locked while busy");
	a_reboot_cause: assert property (reboot_out == $past(boot))
		else $error("restart pulse mismatch");
	a_marker_clear: assert property (obj_write_in && !wr_in
		|=> marker_out == 64'h0) else $error("marker not cleared");
	a_marker_write: assert property (wr_in && addr_in == 8'h84
		|=> marker_out.date == $past(wr_data_in)) else $error("marker date not written");
	cover property (nv_req_out.valid && nv_req_out.op == psc_pkg::PSC_OP_SAVE);
	cover property (nv_req_out.valid && nv_req_out.op == psc_pkg::PSC_OP_DISCARD);
	cover property (reboot_out);
endmodule
bind psc_parameter_store_control psc_parameter_store_control_assertions chk (.clock_in,
	.rst_n_in, .addr_in, .wr_data_in, .wr_in, .rd_in, .obj_write_in, .nv_done_in,
	.rd_data_out, .nv_req_out, .marker_out, .reboot_out, .motion_lock_out, .irq_out);
`default_nettype wire

// >>> sim/psc_parameter_store_control_tb.sv
// self-checking bench for the parameter store control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module psc_parameter_store_control_tb;
	logic                 clk, rst_n, wr_s, rd_s, obj_w, slow, done, reboot, lock, irq;
	logic [7:0]           addr, a;
	logic [31:0]          wdata, rdata, d;
	psc_pkg::psc_nv_req_t req;
	psc_pkg::psc_marker_t marker;
	int                   fails, samples_checked;
	logic [3:0]           subs [7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hB};
	logic [6:0]           cats [7] = '{7'h5F, 7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20};
	psc_parameter_store_control dut (.clock_in(clk), .rst_n_in(rst_n), .addr_in(addr),
		.wr_data_in(wdata), .wr_in(wr_s), .rd_in(rd_s), .rd_data_out(rdata),
		.obj_write_in(obj_w), .nv_req_out(req), .marker_out(marker), .nv_done_in(done),
		.reboot_out(reboot), .motion_lock_out(lock), .irq_out(irq));
	psc_nv_model partner (.clock_in(clk), .rst_n_in(rst_n), .nv_req_in(req),
		.slow_in(slow), .nv_done_out(done));
	task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
		@(posedge clk);
		addr <= ad;
		wdata <= dt;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] ad);
		@(posedge clk);
		addr <= ad;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 d = rdata;
	endtask
	// master keeps reading until the word turns to one
	task automatic poll(input logic [7:0] ad);
		int n;
		n = 0;
		d = 32'h0;
		while (d !== 32'h1 && n < 40)
		begin
			rd(ad);
			n++;
		end
		`CHK(d, 32'h1)
		if (d !== 32'h1) results();
	endtask
	task automatic results;
		if (fails == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial
	begin
		{rst_n, wr_s, rd_s, obj_w, slow} = 5'h00;
		addr = 8'h00;
		wdata = 32'h0;
		fails = 0;
		samples_checked = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		#1 `CHK({req, lock}, {3'h4, 7'h7F, 1'b1})
		poll(8'h94);
		for (int i = 0; i < 7; i++)
		begin
			a = {2'h0, subs[i], 2'h0};
			slow = i[0];
			wr(a, 32'h65766173);
			`CHK(req, {3'h5, cats[i]})
			rd(a);
			`CHK(d, 32'h65766173)
			poll(a);
			`CHK(lock, 1'b0)
			a = {2'h1, subs[i], 2'h0};
			wr(a, 32'h64616F6C);
			`CHK({req, reboot}, {3'h6, (i == 0) ? 7'h0F : cats[i], 1'b0})
			poll(a);
		end
		wr(8'h08, 32'h12345678);
		`CHK(req.valid, 1'b0)
		wr(8'h90, 32'h0);
		rd(8'h8C);
		`CHK({d, irq}, {32'hF, 1'b0})
		wr(8'h90, 32'h8);
		rd(8'h8C);
		`CHK(irq, 1'b1)
		wr(8'h8C, 32'h8);
		rd(8'h8C);
		`CHK({d, irq}, {32'h7, 1'b0})
		wr(8'h84, 32'hA5A50001);
		wr(8'h88, 32'h00001234);
		`CHK(marker, 64'hA5A5000100001234)
		@(posedge clk);
		obj_w <= 1'b1;
		@(posedge clk);
		obj_w <= 1'b0;
		#1 `CHK(marker, 64'h0)
		wr(8'h84, 32'hA5A50001);
		wr(8'h04, 32'h65766173);
		`CHK({marker.date, req.cats[6]}, {32'hA5A50001, 1'b1})
		poll(8'h04);
		wr(8'h08, 32'h65766173);
		`CHK(marker, 64'h0)
		poll(8'h08);
		wr(8'h80, 32'h746F6F63);
		`CHK(reboot, 1'b0)
		wr(8'h80, 32'h746F6F62);
		`CHK(reboot, 1'b1)
		rd(8'hFC);
		`CHK(d, 32'h0)
		results();
	end
endmodule
`default_nettype wire
